// *** verilog/dwc_top.sv ***
`timescale 1ns/10ps
`include "dwc_params.svh"
module dwc_top
  import dwc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_high,
  input  wire logic       addr_strap_mid,
  input  wire logic       addr_strap_low,
  output logic [7:0]      wiper_a_pos,
  output logic [7:0]      wiper_b_pos
);

  dwc_pins_s  pins_raw;  // Pin levels as they arrive.
  dwc_pins_s  pins;      // Pin levels after synchronisation.
  dwc_state_s cur_ff;    // Registered decoder state.
  dwc_state_s nxt_state; // Next decoder state.
  logic       scl_rise;  // Clock line went high.
  logic       scl_fall;  // Clock line went low.
  logic       bus_start; // Data fell while clock was high.
  logic       bus_stop;  // Data rose while clock was high.
  logic       addr_ok;   // Received address names this device.
  logic [1:0] sel;       // Wipers chosen by the held command, B in bit 1.

  // Decodes a command byte into the pair of wipers it selects.
  function automatic logic [1:0] wiper_select(input logic [7:0] cmd);
    logic [1:0] res;
    res = 2'h0;
    case (cmd)
      `DWC_CMD_A:  res = 2'h1; // R4
      `DWC_CMD_B:  res = 2'h2; // R4
      `DWC_CMD_AB: res = 2'h3; // R4
      default:     res = 2'h0; // R13
    endcase
    return res;
  endfunction

  // Pins are bundled and passed through the synchroniser.
  assign pins_raw = '{scl: scl_in, sda: sda_in,
                      strap: {addr_strap_high, addr_strap_mid, addr_strap_low}};

  dwc_sync u_sync
  (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .pins_async (pins_raw),
    .pins_sync  (pins)
  );

  // Edges and bus conditions are found from the current and previous samples.
  assign scl_rise  = pins.scl & ~cur_ff.scl_d;
  assign scl_fall  = ~pins.scl & cur_ff.scl_d;
  assign bus_start = pins.scl & cur_ff.scl_d & cur_ff.sda_d & ~pins.sda;
  assign bus_stop  = pins.scl & cur_ff.scl_d & ~cur_ff.sda_d & pins.sda;
  assign addr_ok   = (cur_ff.shift[7:1] == {`DWC_ADDR_HI, pins.strap}); // R10
  assign sel       = wiper_select(cur_ff.cmd);

  // Frame decoder: shifts bits on clock rises, acts on clock falls.
  always_comb
  begin
    nxt_state       = cur_ff;
    nxt_state.scl_d = pins.scl;
    nxt_state.sda_d = pins.sda;
    if (bus_start)
    begin
      // A start, repeated or not, abandons any partial frame.
      nxt_state.phase   = DWC_ADDR;
      nxt_state.bit_cnt = `DWC_CNT_ZERO;
      nxt_state.sda_oe  = 1'b0; // R13
    end
    else if (bus_stop)
    begin
      // A stop always frees the data line.
      nxt_state.phase   = DWC_IDLE;
      nxt_state.bit_cnt = `DWC_CNT_ZERO;
      nxt_state.sda_oe  = 1'b0;
    end
    else
    begin
      case (cur_ff.phase)
        DWC_ADDR, DWC_CMD, DWC_DATA:
        begin
          if (scl_rise && (cur_ff.bit_cnt < `DWC_BYTE_BITS))
          begin
            // Bits arrive most significant first.
            nxt_state.shift   = {cur_ff.shift[6:0], pins.sda}; // R2 R3
            nxt_state.bit_cnt = cur_ff.bit_cnt + `DWC_CNT_ONE;
          end
          else if (scl_fall && (cur_ff.bit_cnt == `DWC_BYTE_BITS))
          begin
            // Eighth bit done: decide on the acknowledge slot.
            nxt_state.bit_cnt = `DWC_ACK_SLOT;
            case (cur_ff.phase)
              DWC_ADDR:
              begin
                if (addr_ok)
                begin
                  nxt_state.sda_oe = 1'b1; // R1
                  nxt_state.noop   = (cur_ff.shift[0] != `DWC_WRITE_BIT); // R9
                end
                else
                begin
                  // Another device is addressed; stay off the bus.
                  nxt_state.phase   = DWC_IGNORE; // R10
                  nxt_state.bit_cnt = `DWC_CNT_ZERO;
                end
              end
              DWC_CMD:
              begin
                nxt_state.cmd    = cur_ff.shift;
                nxt_state.sda_oe = 1'b1; // R2
              end
              default:
              begin
                // Data byte complete: write the chosen wipers at once.
                nxt_state.sda_oe = 1'b1; // R3
                if (sel[0])
                begin
                  nxt_state.wiper_a = cur_ff.shift; // R4 R7 R11 R12
                end
                if (sel[1])
                begin
                  nxt_state.wiper_b = cur_ff.shift; // R5 R6 R7 R12
                end
              end
            endcase
          end
          else if (scl_fall && (cur_ff.bit_cnt == `DWC_ACK_SLOT))
          begin
            // Acknowledge clock ended: release data, move to the next phase.
            nxt_state.sda_oe  = 1'b0;
            nxt_state.bit_cnt = `DWC_CNT_ZERO;
            case (cur_ff.phase)
              DWC_ADDR: nxt_state.phase = cur_ff.noop ? DWC_IGNORE : DWC_CMD; // R9
              DWC_CMD:  nxt_state.phase = DWC_DATA;
              default:  nxt_state.phase = DWC_DONE;
            endcase
          end
        end
        default:
        begin
          // Idle, done and ignore wait for the next start or stop.
          nxt_state.phase = cur_ff.phase;
        end
      endcase
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_ff <= '{phase: DWC_IDLE, bit_cnt: `DWC_CNT_ZERO, shift: `DWC_BYTE_CLR,
                  cmd: `DWC_BYTE_CLR,
                  noop: 1'b0, scl_d: 1'b1, sda_d: 1'b1, sda_oe: 1'b0, sda_out: 1'b0,
                  wiper_a: `DWC_WIPER_RST, wiper_b: `DWC_WIPER_RST}; // R8
    end
    else if (clk_en)
    begin
      cur_ff <= nxt_state;
    end
  end

  // Every output is a field of the state register.
  assign sda_out     = cur_ff.sda_out;
  assign sda_oe      = cur_ff.sda_oe;
  assign wiper_a_pos = cur_ff.wiper_a; // R11
  assign wiper_b_pos = cur_ff.wiper_b; // R6

  default clocking dwc_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // End of the eighth bit of a byte in a given phase.
  sequence s_byte_end(dwc_phase_e ph);
    clk_en && !bus_start && !bus_stop && (cur_ff.phase == ph) && scl_fall
      && (cur_ff.bit_cnt == `DWC_BYTE_BITS);
  endsequence

  // End of the acknowledge clock in a given phase.
  sequence s_ack_end(dwc_phase_e ph);
    clk_en && !bus_start && !bus_stop && (cur_ff.phase == ph) && scl_fall
      && (cur_ff.bit_cnt == `DWC_ACK_SLOT);
  endsequence

  // A matching address is acknowledged with the line driven low.
  AST_ADDR_ACK: assert property (s_byte_end(DWC_ADDR) ##0 addr_ok |=> // R1
    sda_oe && !sda_out)
    else $error("Matching address not acknowledged.");

  // A foreign address is never acknowledged.
  AST_ADDR_NACK: assert property (s_byte_end(DWC_ADDR) ##0 !addr_ok |=> // R10
    !sda_oe && (cur_ff.phase == DWC_IGNORE))
    else $error("Foreign address acknowledged.");

  // Command byte acknowledged, with the phase still command during the ack clock.
  AST_CMD_ACK: assert property (s_byte_end(DWC_CMD) |=> sda_oe // R2
    && (cur_ff.phase == DWC_CMD))
    else $error("Command byte not acknowledged.");

  // Line released and phase moved to done after the data byte's ack clock.
  AST_DATA_ACK: assert property (s_ack_end(DWC_DATA) |=> !sda_oe // R3
    && (cur_ff.phase == DWC_DONE))
    else $error("Data byte acknowledge not closed properly.");

  // Register A command moves only wiper A.
  AST_WR_A: assert property (s_byte_end(DWC_DATA) ##0 (cur_ff.cmd == `DWC_CMD_A) |=> // R4
    (wiper_a_pos == $past(cur_ff.shift)) && $stable(wiper_b_pos))
    else $error("Register A write wrong.");

  // Register B command moves only wiper B.
  AST_WR_B: assert property (s_byte_end(DWC_DATA) ##0 (cur_ff.cmd == `DWC_CMD_B) |=> // R5
    (wiper_b_pos == $past(cur_ff.shift)) && $stable(wiper_a_pos))
    else $error("Register B write wrong.");

  // Both command moves both wipers to the same value.
  AST_WR_AB: assert property (s_byte_end(DWC_DATA) ##0 (cur_ff.cmd == `DWC_CMD_AB) |=> // R7
    (wiper_a_pos == $past(cur_ff.shift)) && (wiper_b_pos == wiper_a_pos))
    else $error("Dual write wrong.");

  // Wipers change only at the end of a full data byte with a valid command.
  // The write condition is spelled out because a sequence cannot be negated as a value.
  AST_NO_WRITE: assert property (!(clk_en && !bus_start && !bus_stop // R13
    && (cur_ff.phase == DWC_DATA) && scl_fall && (cur_ff.bit_cnt == `DWC_BYTE_BITS)
    && (sel != 2'h0)) |=> $stable(wiper_a_pos) && $stable(wiper_b_pos))
    else $error("Wiper changed without a valid write.");

  // A no-operation address leads to the ignore phase.
  AST_NOOP: assert property (s_ack_end(DWC_ADDR) ##0 cur_ff.noop |=> // R9
    (cur_ff.phase == DWC_IGNORE))
    else $error("No-operation frame not ignored.");

  // Wipers sit at midscale as reset is released.
  AST_RESET_MID: assert property ($rose(arst_n) |-> // R8
    (wiper_a_pos == `DWC_WIPER_RST) && (wiper_b_pos == `DWC_WIPER_RST))
    else $error("Wipers not at midscale after reset.");

endmodule

// *** verilog/dwc_params.svh ***
// Functional notes
// R1 - Acknowledge address byte, write bit, on match.
// R2 - Acknowledge command byte on clock eighteen.
// R3 - Acknowledge data byte on clock twenty-seven.
// R4 - Commands 11h, 12h, 13h select A, B, both.
// R5 - Register B command loads data into wiper B.
// R6 - Wiper B code maps linearly low to high.
// R7 - Both command writes same byte to both.
// R8 - Both wipers reset to 80h midscale.
// R9 - Eighth address bit one is no-operation; no readback.
// R10 - Address is 0101 plus three strap inputs.
// R11 - Wiper A code maps linearly low to high.
// R12 - Written data drives the tap immediately.
// R13 - Unknown command or short frame changes nothing.
`ifndef DWC_PARAMS_SVH
`define DWC_PARAMS_SVH
// Fixed upper four bits of the slave address.
`define DWC_ADDR_HI     4'h5
// Value of the write-or-noop bit that asks for a write.
`define DWC_WRITE_BIT   1'b0
// Wiper position after reset, the midscale tap.
`define DWC_WIPER_RST   8'h80
// Cleared shift and command byte after reset.
`define DWC_BYTE_CLR    8'h00
// Command codes.
`define DWC_CMD_A       8'h11
`define DWC_CMD_B       8'h12
`define DWC_CMD_AB      8'h13
// Bit counter landmarks within one nine-clock byte slot.
`define DWC_CNT_ZERO    4'h0
`define DWC_CNT_ONE     4'h1
`define DWC_BYTE_BITS   4'h8
`define DWC_ACK_SLOT    4'h9
`endif

// *** verilog/dwc_pkg.sv ***
package dwc_pkg;

  // Frame phase; Gray coded along idle, address, command, data, done.
  typedef enum logic [2:0]
  {
    DWC_IDLE   = 3'h0,
    DWC_ADDR   = 3'h1,
    DWC_CMD    = 3'h3,
    DWC_DATA   = 3'h2,
    DWC_DONE   = 3'h6,
    DWC_IGNORE = 3'h7
  } dwc_phase_e;

  // Bus and strap levels that arrive from outside the clock domain.
  typedef struct packed
  {
    logic       scl;
    logic       sda;
    logic [2:0] strap;
  } dwc_pins_s;

  // Two-stage synchroniser state.
  typedef struct packed
  {
    dwc_pins_s first;
    dwc_pins_s second;
  } dwc_sync_s;

  // Whole state of the command decoder.
  typedef struct packed
  {
    dwc_phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic       noop;
    logic       scl_d;
    logic       sda_d;
    logic       sda_oe;
    logic       sda_out;
    logic [7:0] wiper_a;
    logic [7:0] wiper_b;
  } dwc_state_s;

endpackage

// *** verilog/dwc_sync.sv ***
`timescale 1ns/10ps
module dwc_sync
  import dwc_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  input  wire logic      clk_en,
  input  wire dwc_pins_s pins_async,
  output dwc_pins_s      pins_sync
);

  dwc_sync_s cur_ff;   // Registered synchroniser state.
  dwc_sync_s nxt_sync; // Next synchroniser state.

  // The first stage feeds only the second stage.
  always_comb
  begin
    nxt_sync        = cur_ff;
    nxt_sync.first  = pins_async;
    nxt_sync.second = cur_ff.first;
  end

  // Both stages reset to an idle bus with all straps low.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_ff <= '{first: '{scl: 1'b1, sda: 1'b1, strap: 3'h0},
                  second: '{scl: 1'b1, sda: 1'b1, strap: 3'h0}};
    end
    else if (clk_en)
    begin
      cur_ff <= nxt_sync;
    end
  end

  // Only the second stage leaves the module.
  assign pins_sync = cur_ff.second;

endmodule

// *** tb/dwc_master_model.sv ***
`timescale 1ns/10ps
// Bus master on the far side: it drives SCL and releases SDA to the pull-up.
module dwc_master_model
(
  input  wire logic ref_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv,
  output logic      ack_valid,
  output logic      ack_bit
);
  // The bus idles high and the clock stands still between frames.
  initial
  begin
    scl       = 1'b1;
    sda_drv   = 1'b1;
    ack_valid = 1'b0;
    ack_bit   = 1'b0;
  end

  // Waits half of the 320 ns link period.
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask

  // Changes SDA one cycle after SCL has fallen, never while SCL is high.
  task automatic set_sda(input logic v);
    @(negedge ref_clk);
    sda_drv = v;
    repeat (3) @(negedge ref_clk);
  endtask

  // Opens a frame: SDA falls while SCL is high.
  task automatic start();
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask

  // Closes a frame: SDA rises while SCL is high.
  task automatic stop();
    set_sda(1'b0);
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask

  // Sends n bits MSB first; a whole byte gets a ninth clock for the answer.
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      set_sda(b[7-i]);
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    if (n == 8)
    begin
      set_sda(1'b1);
      scl = 1'b1;
      half();
      ack_bit   = ~sda_bus;
      ack_valid = 1'b1;
      scl       = 1'b0;
      @(negedge ref_clk);
      ack_valid = 1'b0;
    end
  endtask
endmodule

// *** tb/dual_wiper_i2c_command_decode_test.sv ***
`timescale 1ns/10ps
module dual_wiper_i2c_command_decode_test;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        clk_en  = 1'b1;
  logic [2:0]  strap   = 3'h0;
  logic        scl;
  logic        sda_drv;
  logic        sda_oe;
  logic        sda_out;
  logic        ack_valid;
  logic        ack_bit;
  logic [7:0]  wa;
  logic [7:0]  wb;
  logic [7:0]  cur_a;
  logic [7:0]  cur_b;
  logic [15:0] last_wip;
  logic        exp_ack[$];
  logic [15:0] exp_wip[$];
  int          miscompares = 0;
  int          n_compared  = 0;
  // Open-drain data wire with its pull-up.
  wire         sda_bus = sda_drv & ~(sda_oe & ~sda_out);

  // Free-running 25 MHz reference clock.
  always #20 ref_clk = ~ref_clk;

  dwc_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high(strap[2]),
    .addr_strap_mid(strap[1]), .addr_strap_low(strap[0]), .wiper_a_pos(wa), .wiper_b_pos(wb));

  dwc_master_model m (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv),
    .ack_valid(ack_valid), .ack_bit(ack_bit));

  // Compares an acknowledge answer.
  task automatic check_ack(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ack got %b exp %b", $time, got, exp);
    end
  endtask

  // Compares the pair of wiper positions.
  task automatic check_wip(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t wipers got %h exp %h", $time, got, exp);
    end
  endtask

  // Watcher: each answer or wiper change takes the oldest note off its queue.
  always @(posedge ref_clk)
  begin
    if (ack_valid)
      check_ack(ack_bit, exp_ack.size() ? exp_ack.pop_front() : 1'bx);
    if (arst_n && {wa, wb} !== last_wip)
      check_wip({wa, wb}, exp_wip.size() ? exp_wip.pop_front() : 16'hXXXX);
    last_wip <= {wa, wb};
  end

  // Notes the expected answer, then sends n bits.
  task automatic xfer(input logic [7:0] b, input int n, input logic e);
    if (n == 8)
      exp_ack.push_back(e);
    m.send(b, n);
  endtask

  // Checks the held wipers and that every note was consumed.
  task automatic end_test(input string name);
    check_wip({wa, wb}, {cur_a, cur_b});
    check_ack(exp_ack.size() == 0 && exp_wip.size() == 0, 1'b1);
    $display("test %s done, miscompares %0d", name, miscompares);
  endtask

  // Full write frame of nd data bits, with an optional unanswered extra byte.
  task automatic wr_check(input logic [7:0] c, input logic [7:0] d, input int nd,
                          input logic ex);
    logic [7:0] na;
    logic [7:0] nb;
    na = (nd == 8 && (c == 8'h11 || c == 8'h13)) ? d : cur_a;
    nb = (nd == 8 && (c == 8'h12 || c == 8'h13)) ? d : cur_b;
    if ({na, nb} !== {cur_a, cur_b})
      exp_wip.push_back({na, nb});
    cur_a = na;
    cur_b = nb;
    m.start();
    xfer({4'h5, strap, 1'b0}, 8, 1'b1);
    xfer(c, 8, 1'b1);
    xfer(d, nd, 1'b1);
    if (ex)
      xfer(8'hA5, 8, 1'b0);
    m.stop();
    end_test("write");
  endtask

  // Ends the run with the counts and the verdict.
  task automatic finish_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #2000000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(91892));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    cur_a  = 8'h80;
    cur_b  = 8'h80;
    repeat (4) @(negedge ref_clk);
    check_wip({wa, wb}, 16'h8080);
    // Every command with low end, high end and random positions.
    for (int i = 0; i < 9; i++)
    begin
      strap = 3'($urandom);
      repeat (4) @(negedge ref_clk);
      wr_check(8'h11 + 8'(i % 3), (i < 3) ? 8'h00 : (i < 6) ? 8'hFF : 8'($urandom), 8, 1'b0);
    end
    wr_check(8'h14, 8'($urandom), 8, 1'b0);
    wr_check(8'h10, 8'h5A, 8, 1'b0);
    wr_check(8'h13, 8'h3C, 5, 1'b0);
    wr_check(8'h12, 8'h69, 8, 1'b1);
    // Foreign addresses get no answer and write nothing.
    for (int i = 0; i < 2; i++)
    begin
      m.start();
      xfer(i ? {4'h4, strap, 1'b0} : {4'h5, ~strap, 1'b0}, 8, 1'b0);
      m.stop();
      end_test("address");
    end
    // No-operation bit: the address is answered, the rest is ignored.
    m.start();
    xfer({4'h5, strap, 1'b1}, 8, 1'b1);
    xfer(8'h13, 8, 1'b0);
    m.stop();
    end_test("noop");
    // A frame sent while the clock enable is low is neither answered nor applied.
    clk_en = 1'b0;
    m.start();
    xfer({4'h5, strap, 1'b0}, 8, 1'b0);
    xfer(8'h13, 8, 1'b0);
    xfer(8'hC3, 8, 1'b0);
    m.stop();
    clk_en = 1'b1;
    end_test("freeze");
    // A reset in mid-run returns both wipers to midscale, then writes work again.
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    cur_a  = 8'h80;
    cur_b  = 8'h80;
    repeat (4) @(negedge ref_clk);
    check_wip({wa, wb}, 16'h8080);
    end_test("reset");
    wr_check(8'h11, 8'hC3, 8, 1'b0);
    finish_test();
  end
endmodule
